/* File: silent_chopper_pkg.sv */
// Constants, register map and types of the silent chopper amplitude block.
// Assumes a single 20 MHz clock and an AXI4-Lite master for the registers.
// Contract
// - Chopper frequency is clock times 2/1024, 2/683, 2/512 or 2/410.
// - With both automatic enables set, run current is regulated toward target.
// - Automatic mode measures coil current, adjusts amplitude by gain field.
// - During motion tuning the regulator also tracks velocity-caused changes.
// - Without decay sensing, coil current is sampled only during on phase.
// - With decay sensing, current is also sampled during slow decay.
// - Decay sensing enable sits at bit 22 of the chopper configuration.
// - Blanking time and chopper frequency bound the smallest usable on-time.
// - Reduced currents use tuned, or manual, offset and gradient values.
// - With freewheeling selected the motor current may reach zero.
// - Pure velocity feed-forward applies whenever autoscale or autograd is off.
// - Velocity input is clocks between microsteps at 256-step resolution.
// - Sum is offset times (scale+1)/32 plus gradient times 256/interval.
// - Active scale follows hold and run current, or load reduction if on.
// - Output amplitude is 8 bits with sine peak 248.
// - Tuned offset and gradient are readable by software.
// - Total amplitude saturates at 1023 and flags lost current headroom.
package silent_chopper_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_STEP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TUNED = 8'h10;
  localparam logic [31:0] CONFIG_RESET = 32'h010C_0000;
  localparam logic [31:0] CURRENT_RESET = 32'h0000_1F10;
  localparam logic [31:0] STEP_RESET = 32'h000F_FFFF;
  localparam logic [31:0] CONFIG_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] CURRENT_MASK = 32'h1F01_1F1F;
  localparam logic [31:0] STEP_MASK = 32'h000F_FFFF;
  localparam int CFG_OFS_LSB = 0;
  localparam int CFG_GRAD_LSB = 8;
  localparam int CFG_FREQ_LSB = 16;
  localparam int CFG_AUTOSCALE_BIT = 18;
  localparam int CFG_AUTOGRAD_BIT = 19;
  localparam int CFG_BLANK_LSB = 20;
  localparam int CFG_DECAY_SENSE_BIT = 22;
  localparam int CFG_FREEWHEEL_BIT = 23;
  localparam int CFG_GAIN_LSB = 24;
  localparam int CUR_HOLD_LSB = 0;
  localparam int CUR_RUN_LSB = 8;
  localparam int CUR_LOAD_EN_BIT = 16;
  localparam int CUR_LOAD_LSB = 24;
  localparam int STAT_SAT_BIT = 16;
  localparam int TUNED_GRAD_LSB = 8;
  localparam logic [19:0] STEP_STANDSTILL = 20'hF_FFFF;
  localparam logic [9:0] AMP_MAX = 10'h3FF;
  localparam logic [7:0] DUTY_MAX = 8'hFF;
  localparam logic [8:0] SINE_PEAK = 9'h0F8;
  localparam logic [15:0] QUOT_MAX = 16'hFFFF;
  localparam int TARGET_SHIFT = 3;
  localparam int REG_SHIFT = 3;
  localparam logic [10:0] REG_LIMIT = 11'h3FF;
  localparam logic [2:0] ADAPT_LAST = 3'h7;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } div_state_t;

  // Full chopper divisor; one triangle of this length holds two periods.
  function automatic logic [10:0] freq_divisor(input logic [1:0] sel);
    case (sel)
      2'h0: freq_divisor = 11'h400;
      2'h1: freq_divisor = 11'h2AB;
      2'h2: freq_divisor = 11'h200;
      default: freq_divisor = 11'h19A;
    endcase
  endfunction

  function automatic logic [9:0] blank_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: blank_cycles = 10'h010;
      2'h1: blank_cycles = 10'h018;
      2'h2: blank_cycles = 10'h024;
      default: blank_cycles = 10'h036;
    endcase
  endfunction
endpackage

/* File: grad_div_if.sv */
// Carrier between the amplitude logic and its gradient divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface grad_div_if;
  logic start;
  logic [15:0] numer;
  logic [19:0] denom;
  logic done;
  logic [15:0] quot;
  modport requester (output start, output numer, output denom,
                     input done, input quot);
  modport divider (input start, input numer, input denom,
                   output done, output quot);
endinterface

/* File: grad_divider.sv */
// Sequential restoring divider for the velocity gradient term.
// Assumes start is a one-cycle pulse and is not repeated while running.
`timescale 1ns/1ps
module grad_divider (
  input wire logic aclk,
  input wire logic aresetn,
  grad_div_if.divider div
);
  silent_chopper_pkg::div_state_t state_reg, state_next;
  logic [20:0] rem_reg, rem_next;
  logic [15:0] num_reg, num_next;
  logic [19:0] den_reg, den_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] quot_reg, quot_next;
  logic done_reg, done_next;
  logic [20:0] rem_sh;

  assign div.done = done_reg;
  assign div.quot = quot_reg;

  always_comb begin
    state_next = state_reg;
    rem_next = rem_reg;
    num_next = num_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    quot_next = quot_reg;
    done_next = 1'b0;
    rem_sh = {rem_reg[19:0], num_reg[15]};
    case (state_reg)
      silent_chopper_pkg::DIV_IDLE: begin
        if (div.start) begin
          if (div.denom == 20'h0_0000) begin
            quot_next = silent_chopper_pkg::QUOT_MAX;
            done_next = 1'b1;
          end else begin
            rem_next = 21'h00_0000;
            num_next = div.numer;
            den_next = div.denom;
            cnt_next = 5'h00;
            state_next = silent_chopper_pkg::DIV_RUN;
          end
        end
      end
      silent_chopper_pkg::DIV_RUN: begin
        // Integer quotient, one bit per clock.
        if (rem_sh >= {1'b0, den_reg}) begin
          rem_next = rem_sh - {1'b0, den_reg};
          num_next = {num_reg[14:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          num_next = {num_reg[14:0], 1'b0};
        end
        cnt_next = cnt_reg + 5'h01;
        if (cnt_next == silent_chopper_pkg::DIV_STEPS) begin
          quot_next = num_next;
          done_next = 1'b1;
          state_next = silent_chopper_pkg::DIV_IDLE;
        end
      end
      default: state_next = silent_chopper_pkg::DIV_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= silent_chopper_pkg::DIV_IDLE;
      rem_reg <= 21'h00_0000;
      num_reg <= 16'h0000;
      den_reg <= 20'h0_0000;
      cnt_reg <= 5'h00;
      quot_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rem_reg <= rem_next;
      num_reg <= num_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      quot_reg <= quot_next;
      done_reg <= done_next;
    end
  end
endmodule

/* File: silent_chopper.sv */
// Silent chopper amplitude control with an AXI4-Lite register slave.
// Assumes coil_current is a sense result already on aclk, one code per clock.
`timescale 1ns/1ps
module silent_chopper (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] coil_current,
  output logic pwm_on,
  output logic [7:0] coil_amplitude
);
  grad_div_if gdiv ();

  // Register slave state.
  logic [7:0] awaddr_reg, awaddr_next;
  logic aw_have_reg, aw_have_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic w_have_reg, w_have_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] config_reg, config_next;
  logic [31:0] current_reg, current_next;
  logic [31:0] step_reg, step_next;

  // Chopper and regulator state.
  logic [9:0] pos_reg, pos_next;
  logic half_reg, half_next;
  logic [9:0] on_len_reg, on_len_next;
  logic pwm_on_reg, pwm_on_next;
  logic [7:0] amp_reg, amp_next;
  logic [7:0] meas_reg, meas_next;
  logic meas_valid_reg, meas_valid_next;
  logic signed [10:0] reg_term_reg, reg_term_next;
  logic [7:0] tuned_ofs_reg, tuned_ofs_next;
  logic [7:0] tuned_grad_reg, tuned_grad_next;
  logic [2:0] adapt_reg, adapt_next;
  logic [15:0] quot_reg, quot_next;
  logic [9:0] sum_reg, sum_next;
  logic sat_reg, sat_next;
  logic start_reg, start_next;

  logic [7:0] cfg_ofs, cfg_grad, ofs_src, grad_src;
  logic [1:0] cfg_freq, cfg_blank;
  logic autoscale, autograd, decay_sense, freewheel;
  logic [3:0] gain;
  logic [4:0] hold_i, run_i, load_i, cs;
  logic load_en, standstill, auto_mode, regulating, freewheel_off;
  logic [10:0] divisor;
  logic [9:0] half_len;
  logic period_end;
  logic [13:0] ofs_prod;
  logic signed [17:0] total;
  logic [8:0] target;
  logic signed [9:0] err;
  logic signed [14:0] delta;
  logic signed [11:0] reg_sum;
  logic [16:0] duty_prod;
  logic [7:0] duty;
  logic [17:0] on_prod;
  logic wr_fire;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = res & mask;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == silent_chopper_pkg::ADDR_CONFIG) ||
                (addr == silent_chopper_pkg::ADDR_CURRENT) ||
                (addr == silent_chopper_pkg::ADDR_STEP) ||
                (addr == silent_chopper_pkg::ADDR_STATUS) ||
                (addr == silent_chopper_pkg::ADDR_TUNED);
  endfunction

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pwm_on = pwm_on_reg;
  assign coil_amplitude = amp_reg;
  assign gdiv.start = start_reg;
  assign gdiv.numer = {grad_src, 8'h00};
  assign gdiv.denom = step_reg[19:0];

  grad_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(gdiv)
  );

  // Field decode.
  always_comb begin
    cfg_ofs = config_reg[silent_chopper_pkg::CFG_OFS_LSB +: 8];
    cfg_grad = config_reg[silent_chopper_pkg::CFG_GRAD_LSB +: 8];
    cfg_freq = config_reg[silent_chopper_pkg::CFG_FREQ_LSB +: 2];
    cfg_blank = config_reg[silent_chopper_pkg::CFG_BLANK_LSB +: 2];
    autoscale = config_reg[silent_chopper_pkg::CFG_AUTOSCALE_BIT];
    autograd = config_reg[silent_chopper_pkg::CFG_AUTOGRAD_BIT];
    decay_sense = config_reg[silent_chopper_pkg::CFG_DECAY_SENSE_BIT];
    freewheel = config_reg[silent_chopper_pkg::CFG_FREEWHEEL_BIT];
    gain = config_reg[silent_chopper_pkg::CFG_GAIN_LSB +: 4];
    hold_i = current_reg[silent_chopper_pkg::CUR_HOLD_LSB +: 5];
    run_i = current_reg[silent_chopper_pkg::CUR_RUN_LSB +: 5];
    load_en = current_reg[silent_chopper_pkg::CUR_LOAD_EN_BIT];
    load_i = current_reg[silent_chopper_pkg::CUR_LOAD_LSB +: 5];
    // Step interval in clocks per 1/256 microstep.
    standstill = (step_reg[19:0] == silent_chopper_pkg::STEP_STANDSTILL);
    cs = load_en ? load_i : (standstill ? hold_i : run_i);
    auto_mode = autoscale && autograd;
    // Zero hold current with freewheel lets the coil current reach zero.
    freewheel_off = freewheel && standstill && (hold_i == 5'h00);
    // In automatic mode, below run current the amplitude comes from tuned values only.
    regulating = auto_mode && (cs == run_i) && !freewheel_off;
    ofs_src = autoscale ? tuned_ofs_reg : cfg_ofs;
    grad_src = (autoscale && autograd) ? tuned_grad_reg : cfg_grad;
  end

  // Register slave next state.
  always_comb begin
    awaddr_next = awaddr_reg;
    aw_have_next = aw_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    config_next = config_reg;
    current_next = current_reg;
    step_next = step_reg;
    wr_fire = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_have_next = 1'b1;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      wr_fire = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(awaddr_reg) ? silent_chopper_pkg::RESP_OKAY :
                   silent_chopper_pkg::RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      case (awaddr_reg)
        silent_chopper_pkg::ADDR_CONFIG: config_next = merge(config_reg,
          wdata_reg, wstrb_reg, silent_chopper_pkg::CONFIG_MASK);
        silent_chopper_pkg::ADDR_CURRENT: current_next = merge(current_reg,
          wdata_reg, wstrb_reg, silent_chopper_pkg::CURRENT_MASK);
        silent_chopper_pkg::ADDR_STEP: step_next = merge(step_reg,
          wdata_reg, wstrb_reg, silent_chopper_pkg::STEP_MASK);
        default: begin
        end
      endcase
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = is_mapped(s_axi_araddr) ? silent_chopper_pkg::RESP_OKAY :
                   silent_chopper_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        silent_chopper_pkg::ADDR_CONFIG: rdata_next = config_reg;
        silent_chopper_pkg::ADDR_CURRENT: rdata_next = current_reg;
        silent_chopper_pkg::ADDR_STEP: rdata_next = step_reg;
        silent_chopper_pkg::ADDR_STATUS: begin
          rdata_next = {15'h0000, sat_reg, 6'h00, sum_reg};
        end
        silent_chopper_pkg::ADDR_TUNED: begin
          rdata_next = {16'h0000, tuned_grad_reg, tuned_ofs_reg};
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
  end

  // Chopper timing, sampling, regulation and amplitude next state.
  always_comb begin
    divisor = silent_chopper_pkg::freq_divisor(cfg_freq);
    // An odd divisor splits its triangle into two unequal halves.
    half_len = divisor[10:1] + {9'h000, half_reg & divisor[0]};
    period_end = (pos_reg == half_len - 10'h001);
    pos_next = period_end ? 10'h000 : pos_reg + 10'h001;
    half_next = period_end ? !half_reg : half_reg;
    start_next = period_end;
    quot_next = gdiv.done ? gdiv.quot : quot_reg;
    // Feed-forward amplitude from offset and gradient.
    ofs_prod = {6'h00, ofs_src} * ({9'h000, cs} + 14'h0001);
    total = $signed({9'h000, ofs_prod[13:5]}) +
            $signed({2'h0, quot_reg});
    if (regulating) begin
      total = total + 18'(reg_term_reg);
    end
    if (freewheel_off) begin
      total = 18'sh0_0000;
    end
    if (total < 0) begin
      sum_next = 10'h000;
    end else if (total > $signed({8'h00, silent_chopper_pkg::AMP_MAX})) begin
      sum_next = silent_chopper_pkg::AMP_MAX;
    end else begin
      sum_next = total[9:0];
    end
    sat_next = (sum_reg == silent_chopper_pkg::AMP_MAX);
    // The chopper amplitude is clamped to 8 bits before use.
    amp_next = (sum_reg > {2'h0, silent_chopper_pkg::DUTY_MAX}) ?
               silent_chopper_pkg::DUTY_MAX : sum_reg[7:0];
    duty_prod = {9'h000, amp_reg} * {8'h00, silent_chopper_pkg::SINE_PEAK};
    duty = duty_prod[15:8];
    on_prod = {10'h000, duty} * {8'h00, half_len};
    on_len_next = period_end ? on_prod[17:8] : on_len_reg;
    pwm_on_next = (pos_next < on_len_next);
    // Samples inside blanking are useless, so without decay sensing short
    // on-times never regulate; a shorter blank time lowers that floor.
    meas_next = meas_reg;
    meas_valid_next = meas_valid_reg;
    if (pos_reg >= silent_chopper_pkg::blank_cycles(cfg_blank)) begin
      if (pwm_on_reg || decay_sense) begin
        meas_next = coil_current;
        meas_valid_next = 1'b1;
      end
    end
    target = ({4'h0, cs} + 9'h001) << silent_chopper_pkg::TARGET_SHIFT;
    err = $signed({1'b0, target}) - $signed({2'h0, meas_reg});
    delta = $signed({1'b0, gain}) * err;
    reg_sum = 12'(reg_term_reg) + 12'(delta >>> silent_chopper_pkg::REG_SHIFT);
    reg_term_next = reg_term_reg;
    tuned_ofs_next = tuned_ofs_reg;
    tuned_grad_next = tuned_grad_reg;
    adapt_next = adapt_reg;
    if (period_end) begin
      meas_valid_next = 1'b0;
      // The regulator freezes when not at run current.
      if (regulating && meas_valid_reg) begin
        if (reg_sum > $signed({1'b0, silent_chopper_pkg::REG_LIMIT})) begin
          reg_term_next = $signed(silent_chopper_pkg::REG_LIMIT);
        end else if (reg_sum < -$signed({1'b0, silent_chopper_pkg::REG_LIMIT}))
        begin
          reg_term_next = -$signed(silent_chopper_pkg::REG_LIMIT);
        end else begin
          reg_term_next = reg_sum[10:0];
        end
      end
      if (regulating) begin
        adapt_next = adapt_reg + 3'h1;
        if (adapt_reg == silent_chopper_pkg::ADAPT_LAST) begin
          // Standstill tunes the offset, motion tunes the gradient.
          if (standstill) begin
            if (reg_term_reg > 0 && tuned_ofs_reg != 8'hFF) begin
              tuned_ofs_next = tuned_ofs_reg + 8'h01;
            end else if (reg_term_reg < 0 && tuned_ofs_reg != 8'h00) begin
              tuned_ofs_next = tuned_ofs_reg - 8'h01;
            end
          end else begin
            if (reg_term_reg > 0 && tuned_grad_reg != 8'hFF) begin
              tuned_grad_next = tuned_grad_reg + 8'h01;
            end else if (reg_term_reg < 0 && tuned_grad_reg != 8'h00) begin
              tuned_grad_next = tuned_grad_reg - 8'h01;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= silent_chopper_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= silent_chopper_pkg::RESP_OKAY;
      config_reg <= silent_chopper_pkg::CONFIG_RESET;
      current_reg <= silent_chopper_pkg::CURRENT_RESET;
      step_reg <= silent_chopper_pkg::STEP_RESET;
      pos_reg <= 10'h000;
      half_reg <= 1'b0;
      on_len_reg <= 10'h000;
      pwm_on_reg <= 1'b0;
      amp_reg <= 8'h00;
      meas_reg <= 8'h00;
      meas_valid_reg <= 1'b0;
      reg_term_reg <= 11'sh000;
      tuned_ofs_reg <= 8'h00;
      tuned_grad_reg <= 8'h00;
      adapt_reg <= 3'h0;
      quot_reg <= 16'h0000;
      sum_reg <= 10'h000;
      sat_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      awaddr_reg <= awaddr_next;
      aw_have_reg <= aw_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      config_reg <= config_next;
      current_reg <= current_next;
      step_reg <= step_next;
      pos_reg <= pos_next;
      half_reg <= half_next;
      on_len_reg <= on_len_next;
      pwm_on_reg <= pwm_on_next;
      amp_reg <= amp_next;
      meas_reg <= meas_next;
      meas_valid_reg <= meas_valid_next;
      reg_term_reg <= reg_term_next;
      tuned_ofs_reg <= tuned_ofs_next;
      tuned_grad_reg <= tuned_grad_next;
      adapt_reg <= adapt_next;
      quot_reg <= quot_next;
      sum_reg <= sum_next;
      sat_reg <= sat_next;
      start_reg <= start_next;
    end
  end
endmodule

/* File: silent_chopper_properties.sv */
// Checker of the bus handshakes and chopper spacing at the top ports.
// Assumes it is bound to silent_chopper, whose port names it shares.
`timescale 1ns/1ps
module silent_chopper_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic pwm_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic prev_reg;
  logic prev_next;
  logic [9:0] gap_reg;
  logic [9:0] gap_next;
  // The gap saturates so that a long standstill cannot wrap into a false gap.
  always_comb begin
    prev_next = pwm_on;
    gap_next = (gap_reg == 10'h3FF) ? gap_reg : gap_reg + 10'h001;
    if (pwm_on && !prev_reg) gap_next = 10'h001;
  end
  always_ff @(posedge aclk) begin
    prev_reg <= aresetn ? prev_next : 1'b0;
    gap_reg <= aresetn ? gap_next : 10'h3FF;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read response missing");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0000_0000) else $error("error read carried data");
  a_chop_spacing: assert property ($rose(pwm_on) |->
    gap_reg >= 10'h0CD) else $error("chopper period too short");
endmodule
bind silent_chopper silent_chopper_properties chk (.*);

/* File: coil_model.sv */
// Coil model: sensed current climbs while the bridge drives, then decays.
// Assumes pwm_on is registered on aclk.
`timescale 1ns/1ps
module coil_model (
  input wire logic aclk,
  input wire logic pwm_on,
  output logic [7:0] coil_current
);
  initial coil_current = 8'h00;
  // Slow decay is slower than the rise, as with a real inductive load.
  always @(posedge aclk)
    if (pwm_on && coil_current < 8'hFB) coil_current <= coil_current + 8'h04;
    else if (!pwm_on && coil_current != 8'h00)
      coil_current <= coil_current - 8'h01;
endmodule

/* File: silent_chopper_tb.sv */
// Self-checking bench of the silent chopper over AXI4-Lite.
// Assumes the coil model closes the current loop.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
$display("wrong value %s exp %h saw %h", n, e, s); end end
module silent_chopper_tb;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pwm_on;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
  logic [31:0] s_axi_rdata, d;
  logic [7:0] coil_current, coil_amplitude;
  int fails = 0;
  int n_compared = 0;
  int c, c1, c2;
  silent_chopper dut (.*);
  coil_model coil (.*);
  initial forever #25 aclk = ~aclk;
  // Handshakes are sampled at the falling edge, where they equal the
  // values the next rising edge takes, avoiding a race with the flops.
  task automatic bw(input logic [7:0] a, input logic [31:0] v);
    bit ta, tw, tr;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_bvalid;
      b = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tr);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    bit ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tr);
    s_axi_rready <= 1'h0;
  endtask
  task automatic sts(input logic [31:0] e);
    repeat (2100) @(posedge aclk);
    rd(8'h0C);
    `CHK("sum", e, d)
    `CHK("amp", e[16] ? 8'hFF : e[7:0], coil_amplitude)
  endtask
  task automatic rise(output int n);
    logic p;
    n = 0;
    do begin
      p = pwm_on;
      @(negedge aclk);
      n++;
    end while (!(pwm_on && !p));
  endtask
  task automatic t_regs;
    rd(8'h00);
    `CHK("config", 32'h010C_0000, d)
    rd(8'h04);
    `CHK("current", 32'h0000_1F10, d)
    rd(8'h08);
    `CHK("step", 32'h000F_FFFF, d)
    rd(8'h14);
    `CHK("hole", {2'h2, 32'h0000_0000}, {r, d})
    bw(8'h14, 32'hFFFF_FFFF);
    `CHK("hole write", 2'h2, b)
  endtask
  task automatic t_ff;
    bw(8'h00, 32'h0040_1040);
    rd(8'h00);
    `CHK("decay bit", 32'h0040_1040, d)
    sts(32'(64 * 17 / 32));
    bw(8'h08, 32'h0000_0100);
    sts(32'(64 * 32 / 32 + 16 * 256 / 256));
    bw(8'h08, 32'h0000_0000);
    sts(32'h0001_03FF);
    bw(8'h04, 32'h0701_1F10);
    bw(8'h08, 32'h0000_0100);
    sts(32'(64 * 8 / 32 + 16));
    bw(8'h04, 32'h0000_1F10);
  endtask
  task automatic t_freq;
    logic [10:0] dv [4] = '{11'h400, 11'h2AB, 11'h200, 11'h19A};
    for (int k = 0; k < 4; k++) begin
      bw(8'h00, 32'h0040_1040 | 32'(k << 16));
      repeat (2100) @(posedge aclk);
      rise(c);
      rise(c1);
      rise(c2);
      `CHK("period", dv[k], 11'(c1 + c2))
    end
  endtask
  task automatic t_free;
    bw(8'h00, 32'h0080_1040);
    bw(8'h04, 32'h0000_1F00);
    bw(8'h08, 32'h000F_FFFF);
    sts(32'h0000_0000);
  endtask
  task automatic t_auto;
    bw(8'h00, 32'h014C_1040);
    bw(8'h04, 32'h0000_0808);
    repeat (4200) @(posedge aclk);
    rd(8'h0C);
    `CHK("headroom", 1'h0, d[16])
    `CHK("regulating", 1'h1, d[9:0] != 10'h000)
    rd(8'h10);
    `CHK("tuned resp", 2'h0, r)
    bw(8'h04, 32'h0000_0803);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge aclk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_ff;
    t_freq;
    t_free;
    t_auto;
    give_verdict;
  end
endmodule
